/* File: design/fsbdp_map.vh */
// Constants for the front-side bus data-phase block.
`ifndef FSBDP_MAP_VH
`define FSBDP_MAP_VH

// ****************************************
// Bus geometry
// ****************************************
`define FSBDP_DATA_W      64
`define FSBDP_GRP_W       16
`define FSBDP_NGRP        4
`define FSBDP_HALF_GRP    5'h08

// ****************************************
// Pin reset levels (active-low pins rest high)
// ****************************************
`define FSBDP_PIN_IDLE    1'b1
`define FSBDP_OE_RST      1'b0

// ****************************************
// Timing
// ****************************************
`define FSBDP_SYS_PERIOD_NS   100
`define FSBDP_LINK_PERIOD_NS  800
`define FSBDP_SYNC_STAGES     2

`endif

/* File: design/fsbdp_group.v */
// One 16-bit data group: inversion encoder, decoder and group parity.
`timescale 1ns/1ns
`include "fsbdp_map.vh"

module fsbdp_group #(
    parameter GW = `FSBDP_GRP_W
) (
    // Transmit side, logical data in, pin levels out
    input  wire [GW-1:0] i_tx_data,
    output wire [GW-1:0] o_tx_pin_n,
    output wire          o_tx_inv_n,
    output wire          o_tx_par_n,
    // Receive side, pin levels in, logical data out
    input  wire [GW-1:0] i_rx_pin_n,
    input  wire          i_rx_inv_n,
    input  wire          i_rx_par_n,
    output wire [GW-1:0] o_rx_data,
    output wire          o_rx_par_err
);

    // ****************************************
    // Helpers
    // ****************************************
    function [4:0] fsbdp_ones;
        input [GW-1:0] v;
        integer k;
        begin
            fsbdp_ones = 5'h00;
            for (k = 0; k < GW; k = k + 1) begin
                fsbdp_ones = fsbdp_ones + {4'h0, v[k]};
            end
        end
    endfunction

    // ****************************************
    // Encode
    // ****************************************
    // A logical one is an electrically low pin, so a group with more than
    // half ones would pull more than half its lines low.
    wire tx_inv = (fsbdp_ones(i_tx_data) > `FSBDP_HALF_GRP);

    assign o_tx_pin_n = tx_inv ? i_tx_data : ~i_tx_data;
    assign o_tx_inv_n = ~tx_inv;
    // Parity is even over the logical data, so it is independent of inversion.
    assign o_tx_par_n = ~(^i_tx_data);

    // ****************************************
    // Decode
    // ****************************************
    assign o_rx_data    = (~i_rx_inv_n) ? i_rx_pin_n : ~i_rx_pin_n;
    assign o_rx_par_err = (^o_rx_data) ^ (~i_rx_par_n);

endmodule

/* File: design/fsbdp_top.v */
// Data-phase agent of a shared front-side bus: drives and receives 64-bit data.
`timescale 1ns/1ns
`include "fsbdp_map.vh"

// Operation
// - Our agent holds busy low for the whole time it occupies the data bus.
// - We claim the bus only after seeing busy deasserted by every other agent.
// - Four parity bits accompany the 64 data bits, one per 16-bit group.
// - Data valid is asserted on every transfer; receivers take only valid data.
// - Data valid may drop for idle clocks mid-transfer; receiver ignores those.
// - Receiver latches each group and its inversion bit on its negative strobe.
// - A group with over half ones is sent inverted with its inversion bit set.
// - Receiver also uses the positive strobe of each group to latch data.
module fsbdp_top #(
    parameter DW = `FSBDP_DATA_W,
    parameter GW = `FSBDP_GRP_W,
    parameter NG = `FSBDP_NGRP
) (
    // Clock and reset
    input  wire          i_clk_sys,
    input  wire          i_arst_n,
    // Bus common clock, sampled
    input  wire          i_link_clk,
    // Transmit stream
    input  wire          i_tx_valid,
    input  wire [DW-1:0] i_tx_data,
    input  wire          i_tx_last,
    output wire          o_tx_ready,
    // Receive stream
    output reg  [DW-1:0] o_rx_data,
    output reg           o_rx_valid,
    output reg           o_rx_par_err,
    // Status
    output reg           o_order_order_n_a,
    output wire          o_bus_owned,
    // Data lines
    input  wire [DW-1:0] i_bus_data_n,
    output reg  [DW-1:0] o_bus_data_n,
    output reg           o_bus_data_oe,
    // Parity
    input  wire [NG-1:0] i_data_parity_n,
    output reg  [NG-1:0] o_data_parity_n,
    output reg           o_data_parity_oe,
    // Group inversion
    input  wire [NG-1:0] i_group_invert_n,
    output reg  [NG-1:0] o_group_invert_n,
    output reg           o_group_invert_oe,
    // Strobes
    input  wire [NG-1:0] i_data_strobe_pos_n,
    output reg  [NG-1:0] o_data_strobe_pos_n,
    output reg           o_data_strobe_pos_oe,
    input  wire [NG-1:0] i_data_strobe_neg_n,
    output reg  [NG-1:0] o_data_strobe_neg_n,
    output reg           o_data_strobe_neg_oe,
    // Control
    input  wire          i_data_valid_n,
    output reg           o_data_valid_n,
    output reg           o_data_valid_oe,
    input  wire          i_data_bus_busy_n,
    output reg           o_data_bus_busy_n,
    output reg           o_data_bus_busy_oe,
    input  wire          i_order_n_a
);

    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_OWN  = 3'h2;
    localparam [2:0] ST_REL  = 3'h4;
    localparam SW = DW + 4 * NG + 4;
    reg  [2:0]    st_q;
    reg  [2:0]    st_d;
    reg           done_q;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Every pin passes two flops; edge detectors look only at stage two.
    wire [SW-1:0] raw = {i_link_clk, i_order_n_a, i_data_bus_busy_n, i_data_valid_n,
                         i_data_strobe_neg_n, i_data_strobe_pos_n, i_group_invert_n,
                         i_data_parity_n, i_bus_data_n};
    reg  [SW-1:0] sync1_q;
    reg  [SW-1:0] sync2_q;

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_q <= {SW{`FSBDP_PIN_IDLE}};
            sync2_q <= {SW{`FSBDP_PIN_IDLE}};
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    wire [DW-1:0] s_data_n  = sync2_q[DW-1:0];
    wire [NG-1:0] s_par_n   = sync2_q[DW+NG-1:DW];
    wire [NG-1:0] s_inv_n   = sync2_q[DW+2*NG-1:DW+NG];
    wire [NG-1:0] s_pos_n   = sync2_q[DW+3*NG-1:DW+2*NG];
    wire [NG-1:0] s_neg_n   = sync2_q[DW+4*NG-1:DW+3*NG];
    wire          s_valid_n = sync2_q[SW-4];
    wire          s_busy_n  = sync2_q[SW-3];
    wire          s_order_n_a_n = sync2_q[SW-2];
    wire          s_link    = sync2_q[SW-1];
    reg           link_prev_q;
    reg  [NG-1:0] pos_prev_q;
    reg  [NG-1:0] neg_prev_q;

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            link_prev_q <= `FSBDP_PIN_IDLE;
            pos_prev_q  <= {NG{`FSBDP_PIN_IDLE}};
            neg_prev_q  <= {NG{`FSBDP_PIN_IDLE}};
        end else begin
            link_prev_q <= s_link;
            pos_prev_q  <= s_pos_n;
            neg_prev_q  <= s_neg_n;
        end
    end

    wire          link_rise = s_link & ~link_prev_q;
    wire          link_fall = ~s_link & link_prev_q;
    wire [NG-1:0] pos_fall  = pos_prev_q & ~s_pos_n;
    wire [NG-1:0] neg_fall  = neg_prev_q & ~s_neg_n;

    // ****************************************
    // Group encode and decode
    // ****************************************
    reg  [DW-1:0] hold_data_q;
    reg  [NG-1:0] hold_inv_q;
    reg  [NG-1:0] hold_par_q;
    wire [DW-1:0] enc_data_n;
    wire [NG-1:0] enc_inv_n;
    wire [NG-1:0] enc_par_n;
    wire [DW-1:0] dec_data;
    wire [NG-1:0] dec_perr;
    genvar g;
    generate
        for (g = 0; g < NG; g = g + 1) begin : grp
            fsbdp_group #(.GW(GW)) u_grp (
                .i_tx_data    (i_tx_data[g*GW +: GW]),
                .o_tx_pin_n   (enc_data_n[g*GW +: GW]),
                .o_tx_inv_n   (enc_inv_n[g]),
                .o_tx_par_n   (enc_par_n[g]),
                .i_rx_pin_n   (hold_data_q[g*GW +: GW]),
                .i_rx_inv_n   (hold_inv_q[g]),
                .i_rx_par_n   (hold_par_q[g]),
                .o_rx_data    (dec_data[g*GW +: GW]),
                .o_rx_par_err (dec_perr[g])
            );
        end
    endgenerate

    // ****************************************
    // Bus ownership
    // ****************************************
    // Ownership only starts on a common-clock edge with busy seen high, so the
    // previous driver has really let go.
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (link_rise && i_tx_valid && s_busy_n) begin
                    st_d = ST_OWN;
                end
            end
            ST_OWN: begin
                if (link_rise && done_q) begin
                    st_d = ST_REL;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    assign o_bus_owned = (st_q == ST_OWN);
    // Ready is offered on each common-clock rise while we own the bus, until the last word is taken.
    assign o_tx_ready  = o_bus_owned & link_rise & ~done_q;
    wire   tx_take     = o_tx_ready & i_tx_valid;

    // ****************************************
    // Transmit pins
    // ****************************************
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q                 <= ST_IDLE;
            done_q               <= 1'b0;
            o_bus_data_n         <= {DW{`FSBDP_PIN_IDLE}};
            o_data_parity_n      <= {NG{`FSBDP_PIN_IDLE}};
            o_group_invert_n     <= {NG{`FSBDP_PIN_IDLE}};
            o_data_strobe_pos_n  <= {NG{`FSBDP_PIN_IDLE}};
            o_data_strobe_neg_n  <= {NG{`FSBDP_PIN_IDLE}};
            o_data_valid_n       <= `FSBDP_PIN_IDLE;
            o_data_bus_busy_n    <= `FSBDP_PIN_IDLE;
            o_bus_data_oe        <= `FSBDP_OE_RST;
            o_data_parity_oe     <= `FSBDP_OE_RST;
            o_group_invert_oe    <= `FSBDP_OE_RST;
            o_data_strobe_pos_oe <= `FSBDP_OE_RST;
            o_data_strobe_neg_oe <= `FSBDP_OE_RST;
            o_data_valid_oe      <= `FSBDP_OE_RST;
            o_data_bus_busy_oe   <= `FSBDP_OE_RST;
        end else begin
            st_q <= st_d;
            if (st_q == ST_IDLE && st_d == ST_OWN) begin
                done_q               <= 1'b0;
                o_data_bus_busy_n    <= 1'b0;
                o_data_bus_busy_oe   <= 1'b1;
                o_bus_data_oe        <= 1'b1;
                o_data_parity_oe     <= 1'b1;
                o_group_invert_oe    <= 1'b1;
                o_data_strobe_pos_oe <= 1'b1;
                o_data_strobe_neg_oe <= 1'b1;
                o_data_valid_oe      <= 1'b1;
            end else if (st_d == ST_REL) begin
                // Busy is released with the last word's clock already past.
                o_data_bus_busy_n    <= `FSBDP_PIN_IDLE;
                o_data_valid_n       <= `FSBDP_PIN_IDLE;
                o_data_strobe_pos_n  <= {NG{`FSBDP_PIN_IDLE}};
                o_data_strobe_neg_n  <= {NG{`FSBDP_PIN_IDLE}};
                o_data_bus_busy_oe   <= 1'b0;
                o_bus_data_oe        <= 1'b0;
                o_data_parity_oe     <= 1'b0;
                o_group_invert_oe    <= 1'b0;
                o_data_strobe_pos_oe <= 1'b0;
                o_data_strobe_neg_oe <= 1'b0;
                o_data_valid_oe      <= 1'b0;
            end else if (o_bus_owned && link_rise) begin
                o_data_strobe_neg_n <= {NG{`FSBDP_PIN_IDLE}};
                if (tx_take) begin
                    done_q              <= i_tx_last;
                    o_bus_data_n        <= enc_data_n;
                    o_group_invert_n    <= enc_inv_n;
                    o_data_parity_n     <= enc_par_n;
                    o_data_valid_n      <= 1'b0;
                    o_data_strobe_pos_n <= {NG{1'b0}};
                end else begin
                    o_data_valid_n      <= `FSBDP_PIN_IDLE;
                    o_data_strobe_pos_n <= {NG{`FSBDP_PIN_IDLE}};
                end
            end else if (o_bus_owned && link_fall && !o_data_valid_n) begin
                o_data_strobe_pos_n <= {NG{`FSBDP_PIN_IDLE}};
                o_data_strobe_neg_n <= {NG{1'b0}};
            end
        end
    end

    // ****************************************
    // Receive path
    // ****************************************
    // Our own data is never looped back into the receive stream.
    wire          rx_en = ~o_bus_owned & ~s_busy_n;
    reg  [NG-1:0] vld_q;
    reg  [NG-1:0] got_q;
    wire [NG-1:0] got_set = neg_fall & vld_q & {NG{rx_en}};
    wire          word_in = &got_q;
    wire [NG-1:0] got_d   = (got_q & {NG{~word_in}}) | got_set;
    integer n;
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_data_q   <= {DW{`FSBDP_PIN_IDLE}};
            hold_inv_q    <= {NG{`FSBDP_PIN_IDLE}};
            hold_par_q    <= {NG{`FSBDP_PIN_IDLE}};
            vld_q         <= {NG{1'b0}};
            got_q         <= {NG{1'b0}};
            o_rx_data     <= {DW{1'b0}};
            o_rx_valid    <= 1'b0;
            o_rx_par_err  <= 1'b0;
            o_order_order_n_a <= 1'b0;
        end else begin
            o_order_order_n_a <= ~s_order_n_a_n;
            got_q         <= got_d;
            o_rx_valid    <= word_in;
            if (word_in) begin
                o_rx_data    <= dec_data;
                o_rx_par_err <= |dec_perr;
            end
            for (n = 0; n < NG; n = n + 1) begin
                if (rx_en && pos_fall[n]) begin
                    hold_data_q[n*GW +: GW] <= s_data_n[n*GW +: GW];
                    hold_inv_q[n]           <= s_inv_n[n];
                    hold_par_q[n]           <= s_par_n[n];
                    vld_q[n]                <= ~s_valid_n;
                end else if (rx_en && neg_fall[n]) begin
                    hold_data_q[n*GW +: GW] <= s_data_n[n*GW +: GW];
                    hold_inv_q[n]           <= s_inv_n[n];
                    hold_par_q[n]           <= s_par_n[n];
                end
            end
        end
    end

endmodule

/* File: bench/fsbdp_top_monitor.sv */
// Concurrent checks on the ports of the data-phase agent.
`timescale 1ns/1ns
module fsbdp_top_monitor #(
    parameter DW = 64,
    parameter GW = 16,
    parameter NG = 4
) (
    // Clock, reset and inputs
    input  wire          i_clk_sys,
    input  wire          i_arst_n,
    input  wire          i_data_bus_busy_n,
    input  wire          i_order_n_a,
    // Outputs
    input  wire          o_tx_ready,
    input  wire          o_rx_valid,
    input  wire          o_order_order_n_a,
    input  wire          o_bus_owned,
    input  wire [DW-1:0] o_bus_data_n,
    input  wire [NG-1:0] o_data_parity_n,
    input  wire [NG-1:0] o_group_invert_n,
    input  wire [NG-1:0] o_data_strobe_pos_n,
    input  wire [NG-1:0] o_data_strobe_neg_n,
    input  wire          o_data_valid_n,
    input  wire          o_data_bus_busy_n,
    input  wire          o_data_bus_busy_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    chk_busy_covers: assert property (!o_data_valid_n |->
        !o_data_bus_busy_n && o_data_bus_busy_oe) else $error("valid without busy");
    chk_oe_owned: assert property (o_data_bus_busy_oe |->
        o_bus_owned && !o_data_bus_busy_n) else $error("busy driven while not owner");
    chk_claim_free: assert property ($rose(o_bus_owned) |->
        $past(i_data_bus_busy_n)) else $error("bus claimed while busy");
    chk_ready_owned: assert property (o_tx_ready |->
        o_bus_owned && o_data_bus_busy_oe) else $error("ready while not owner");
    chk_valid_pos: assert property ($fell(o_data_valid_n) |->
        o_data_strobe_pos_n == {NG{1'b0}}) else $error("valid without pos strobe");
    chk_pos_half: assert property ($fell(o_data_strobe_pos_n[0]) |->
        ##[1:8] o_data_strobe_pos_n[0]) else $error("pos strobe stuck low");
    chk_neg_follows: assert property ($rose(o_data_strobe_pos_n[0]) |->
        o_data_strobe_neg_n == {NG{1'b0}}) else $error("neg strobe missing");
    chk_strobe_apart: assert property (o_data_bus_busy_oe |->
        &(o_data_strobe_pos_n | o_data_strobe_neg_n)) else $error("strobes overlap");
    chk_rx_pulse: assert property (o_rx_valid |-> !o_bus_owned ##1 !o_rx_valid)
        else $error("rx valid too long");
    chk_order_n_a_sync: assert property ($past(i_order_n_a, 3) == i_order_n_a &&
        $past(i_order_n_a, 2) == i_order_n_a && $past(i_order_n_a) == i_order_n_a
        |-> o_order_order_n_a == !i_order_n_a) else $error("order_n_a not reported");
    genvar n;
    generate
        for (n = 0; n < NG; n = n + 1) begin : g_grp
            chk_group_parity: assert property (!o_data_valid_n |->
                o_data_parity_n[n] == ~^o_bus_data_n[GW*n +: GW])
                else $error("group parity wrong");
            chk_group_invert: assert property (!o_data_valid_n |->
                (o_group_invert_n[n] ? $countones(o_bus_data_n[GW*n +: GW]) >= GW / 2
                : $countones(o_bus_data_n[GW*n +: GW]) > GW / 2))
                else $error("group inversion wrong");
        end
    endgenerate
endmodule
bind fsbdp_top fsbdp_top_monitor #(.DW(DW), .GW(GW), .NG(NG)) u_mon (.i_clk_sys, .i_arst_n,
    .i_data_bus_busy_n, .i_order_n_a, .o_tx_ready, .o_rx_valid, .o_order_order_n_a, .o_bus_owned,
    .o_bus_data_n, .o_data_parity_n, .o_group_invert_n, .o_data_strobe_pos_n,
    .o_data_strobe_neg_n, .o_data_valid_n, .o_data_bus_busy_n, .o_data_bus_busy_oe);

/* File: bench/fsbdp_peer.sv */
// Behavioural model of another agent that drives data onto the shared bus.
`timescale 1ns/1ns
module fsbdp_peer (
    // Bus common clock
    input  wire        i_link_clk,
    // Pins of this agent
    output reg  [63:0] o_data_n,
    output reg  [3:0]  o_par_n,
    output reg  [3:0]  o_inv_n,
    output reg  [3:0]  o_pos_n,
    output reg  [3:0]  o_neg_n,
    output reg         o_valid_n,
    output reg         o_busy_n,
    output reg         o_oe
);
    integer    g;
    reg [15:0] grp;
    initial begin
        o_data_n = {64{1'b1}};
        {o_par_n, o_inv_n, o_pos_n, o_neg_n} = 16'hFFFF;
        {o_valid_n, o_busy_n, o_oe} = 3'h6;
    end
    // One transfer; a low v keeps valid off so the clock is idle, bad spoils group 0 parity.
    task send(input [63:0] d, input v, input bad);
        begin
            @(posedge i_link_clk);
            #5;
            o_busy_n = 1'b0;
            o_oe = 1'b1;
            @(posedge i_link_clk);
            #5;
            for (g = 0; g < 4; g = g + 1) begin
                grp = d[16*g +: 16];
                o_inv_n[g] = ($countones(grp) > 8) ? 1'b0 : 1'b1;
                o_data_n[16*g +: 16] = o_inv_n[g] ? ~grp : grp;
                o_par_n[g] = ~(^grp) ^ (bad && g == 0);
            end
            o_valid_n = ~v;
            o_pos_n = 4'h0;
            @(negedge i_link_clk);
            #5;
            o_pos_n = 4'hF;
            o_neg_n = 4'h0;
            @(posedge i_link_clk);
            #5;
            o_neg_n = 4'hF;
            o_valid_n = 1'b1;
            @(posedge i_link_clk);
            #5;
            // Busy and the drivers go together, so the bus is never left half owned.
            o_busy_n = 1'b1;
            o_oe = 1'b0;
        end
    endtask
endmodule

/* File: bench/fsbdp_top_bench.sv */
// Self-checking bench for the front-side bus data-phase agent.
`timescale 1ns/1ns
module fsbdp_top_bench;
    reg         i_clk_sys, i_arst_n, i_link_clk, i_tx_valid, i_tx_last, i_order_n_a;
    reg  [63:0] i_tx_data;
    wire [63:0] o_rx_data, o_bus_data_n, i_bus_data_n, p_data_n;
    wire [3:0]  o_data_parity_n, o_group_invert_n, o_data_strobe_pos_n, o_data_strobe_neg_n;
    wire [3:0]  i_data_parity_n, i_group_invert_n, i_data_strobe_pos_n, i_data_strobe_neg_n;
    wire [3:0]  p_par_n, p_inv_n, p_pos_n, p_neg_n;
    wire        o_tx_ready, o_rx_valid, o_rx_par_err, o_order_order_n_a, o_bus_owned;
    wire        o_bus_data_oe, o_data_parity_oe, o_group_invert_oe, o_data_strobe_pos_oe;
    wire        o_data_strobe_neg_oe, o_data_valid_n, o_data_valid_oe, o_data_bus_busy_n;
    wire        o_data_bus_busy_oe, i_data_valid_n, i_data_bus_busy_n, p_valid_n, p_busy_n, p_oe;
    integer     err_total, cmp_count, cyc;
    wire [6:0]  oe_all = {o_bus_data_oe, o_data_parity_oe, o_group_invert_oe,
        o_data_strobe_pos_oe, o_data_strobe_neg_oe, o_data_valid_oe, o_data_bus_busy_oe};
    // Released lines are terminated high, so an undriven pin reads as deasserted.
    assign i_bus_data_n = o_bus_data_oe ? o_bus_data_n : (p_oe ? p_data_n : {64{1'b1}});
    assign i_data_parity_n = o_data_parity_oe ? o_data_parity_n : (p_oe ? p_par_n : 4'hF);
    assign i_group_invert_n = o_group_invert_oe ? o_group_invert_n : (p_oe ? p_inv_n : 4'hF);
    assign i_data_strobe_pos_n = o_data_strobe_pos_oe ? o_data_strobe_pos_n :
        (p_oe ? p_pos_n : 4'hF);
    assign i_data_strobe_neg_n = o_data_strobe_neg_oe ? o_data_strobe_neg_n :
        (p_oe ? p_neg_n : 4'hF);
    assign i_data_valid_n = o_data_valid_oe ? o_data_valid_n : (p_oe ? p_valid_n : 1'b1);
    assign i_data_bus_busy_n = o_data_bus_busy_oe ? o_data_bus_busy_n : (p_oe ? p_busy_n : 1'b1);
    fsbdp_top dut (.i_clk_sys, .i_arst_n, .i_link_clk, .i_tx_valid, .i_tx_data, .i_tx_last,
        .o_tx_ready, .o_rx_data, .o_rx_valid, .o_rx_par_err, .o_order_order_n_a, .o_bus_owned,
        .i_bus_data_n, .o_bus_data_n, .o_bus_data_oe, .i_data_parity_n, .o_data_parity_n,
        .o_data_parity_oe, .i_group_invert_n, .o_group_invert_n, .o_group_invert_oe,
        .i_data_strobe_pos_n, .o_data_strobe_pos_n, .o_data_strobe_pos_oe, .i_data_strobe_neg_n,
        .o_data_strobe_neg_n, .o_data_strobe_neg_oe, .i_data_valid_n, .o_data_valid_n,
        .o_data_valid_oe, .i_data_bus_busy_n, .o_data_bus_busy_n, .o_data_bus_busy_oe,
        .i_order_n_a);
    fsbdp_peer peer (.i_link_clk, .o_data_n(p_data_n), .o_par_n(p_par_n), .o_inv_n(p_inv_n),
        .o_pos_n(p_pos_n), .o_neg_n(p_neg_n), .o_valid_n(p_valid_n), .o_busy_n(p_busy_n),
        .o_oe(p_oe));
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    // The common clock starts at an odd offset so its edges never coincide with system clock edges.
    initial begin
        i_link_clk = 1'b0;
        #137;
        forever #400 i_link_clk = ~i_link_clk;
    end
    always @(posedge i_clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            wrap_up;
        end
    end
    function [63:0] restore(input [63:0] pins, input [3:0] inv_n);
        integer g;
        for (g = 0; g < 4; g = g + 1)
            restore[16*g +: 16] = inv_n[g] ? ~pins[16*g +: 16] : pins[16*g +: 16];
    endfunction
    function [3:0] par_n(input [63:0] d);
        integer g;
        for (g = 0; g < 4; g = g + 1)
            par_n[g] = ~(^d[16*g +: 16]);
    endfunction
    task step(input integer n);
        integer k;
        for (k = 0; k < n; k = k + 1) begin
            @(posedge i_clk_sys);
            #10;
        end
    endtask
    task chk(input [8*10:1] what, input [63:0] exp, input [63:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task tx_word(input [63:0] d, input last, input [3:0] inv_exp);
        integer n;
        begin
            if (!i_tx_valid) i_tx_valid = 1'b1;
            i_tx_data = d;
            i_tx_last = last;
            for (n = 0; n < 100 && o_tx_ready !== 1'b1; n = n + 1) step(1);
            step(1);
            if (last) i_tx_valid = 1'b0;
            chk("tx taken", 1, n < 100);
            chk("tx data", d, restore(o_bus_data_n, o_group_invert_n));
            chk("tx invert", inv_exp, o_group_invert_n);
            chk("tx parity", par_n(d), o_data_parity_n);
            chk("tx valid", 0, o_data_valid_n);
            chk("tx strobe", 0, o_data_strobe_pos_n);
            chk("tx neg", 4'hF, o_data_strobe_neg_n);
            chk("tx oe", 7'h7F, oe_all);
        end
    endtask
    task wait_release;
        integer n;
        begin
            for (n = 0; n < 60 && o_data_bus_busy_oe !== 1'b0; n = n + 1) step(1);
            chk("release", 1, n < 60 && i_data_bus_busy_n === 1'b1);
            chk("release oe", 7'h00, oe_all);
        end
    endtask
    task rx_xfer(input [63:0] d, input v, input bad, input exp_v, input exp_e);
        integer    n;
        reg        got, perr;
        reg [63:0] seen;
        begin
            {got, perr, seen} = 66'h0;
            fork
                peer.send(d, v, bad);
                for (n = 0; n < 60; n = n + 1) begin
                    step(1);
                    if (o_rx_valid === 1'b1 && !got)
                        {got, seen, perr} = {1'b1, o_rx_data, o_rx_par_err};
                end
            join
            chk("rx valid", exp_v, got);
            if (exp_v) chk("rx data", d, seen);
            if (exp_v) chk("rx parity", exp_e, perr);
        end
    endtask
    task sc_tx_pair;
        begin
            tx_word(64'h00FF_01FF_FFFF_0000, 1'b0, 4'h9);
            i_tx_valid = 1'b0;
            step(12);
            chk("tx idle", 1, o_data_valid_n);
            tx_word(64'hFF00_FE00_0000_FFFF, 1'b1, 4'hE);
            wait_release;
        end
    endtask
    task sc_tx_wait;
        integer n;
        reg     early;
        begin
            early = 1'b0;
            fork
                peer.send(64'h0123_4567_89AB_CDEF, 1'b1, 1'b0);
                begin
                    for (n = 0; n < 20 && p_busy_n !== 1'b0; n = n + 1) step(1);
                    step(6);
                    {i_tx_valid, i_tx_data, i_tx_last} = {1'b1, 64'h8000_7FFF_0001_FFFE, 1'b1};
                    while (p_busy_n === 1'b0) begin
                        if (o_tx_ready === 1'b1 || o_bus_owned === 1'b1) early = 1'b1;
                        step(1);
                    end
                end
            join
            chk("tx early", 0, early);
            tx_word(64'h8000_7FFF_0001_FFFE, 1'b1, 4'hA);
            wait_release;
        end
    endtask
    task sc_rx_idle;
        rx_xfer(64'hDEAD_BEEF_0F0F_F0F0, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    task sc_rx_good;
        rx_xfer(64'hFFFF_0001_01FF_1234, 1'b1, 1'b0, 1'b1, 1'b0);
    endtask
    task sc_rx_parity;
        rx_xfer(64'hA5A5_5A5A_FFFF_0000, 1'b1, 1'b1, 1'b1, 1'b1);
    endtask
    task sc_order_n_a;
        begin
            i_order_n_a = 1'b0;
            step(5);
            chk("order_n_a", 1, o_order_order_n_a);
            i_order_n_a = 1'b1;
            step(5);
            chk("order_n_a", 0, o_order_order_n_a);
        end
    endtask
    task wrap_up;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        {err_total, cmp_count, cyc} = 0;
        {i_arst_n, i_tx_valid, i_tx_last, i_order_n_a, i_tx_data} = {4'h1, 64'h0};
        step(20);
        i_arst_n = 1'b1;
        step(2);
        sc_tx_pair;
        sc_tx_wait;
        sc_rx_idle;
        sc_rx_good;
        sc_rx_parity;
        sc_order_n_a;
        wrap_up;
    end
endmodule
